// *** shared/flash_host_pkg.sv ***
package flash_host_pkg;

  // clock and pin timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACC_NS      = 70;   // address_access_time
  localparam int T_PAGE_NS     = 25;   // page_access_time
  localparam int T_WSU_NS      = 20;   // write setup and hold
  localparam int T_WP_NS       = 40;   // write strobe low width
  localparam int T_RP_NS       = 500;  // hardware reset low width
  localparam int T_RH_NS       = 200;  // reset release to first access
  localparam int T_SUSP_US     = 20;   // erase pause limit
  localparam int SYNC_STAGES   = 2;

  localparam int CYC_ACC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PAGE = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WSU  = (T_WSU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_WP   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RP   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RH   = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_SUSP =
    (T_SUSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 11;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_PAGE_BIT  = 3;
  localparam int CTRL_BYTE_BIT  = 4;
  localparam int CTRL_PROT_BIT  = 5;
  localparam int CTRL_HVID_BIT  = 6;
  localparam int CTRL_STCHK_BIT = 7;
  localparam int CTRL_RST_BIT   = 8;
  localparam int CTRL_IDEN_BIT  = 9;
  localparam int CTRL_RESUM_BIT = 10;
  localparam int ADDR_LOW_BIT   = 23;   // extra low bit in byte mode

  // status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_NEEDRST = 1;
  localparam int ST_IDMODE  = 2;
  localparam int ST_SUSP    = 3;
  localparam int ST_RB      = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_PAGE    = 6;

  localparam int TIMEOUT_FLAG_BIT = 5;
  localparam logic [15:0] DQ_OE_WORD = 16'hFFFF;
  localparam logic [15:0] DQ_OE_BYTE = 16'h80FF;
  localparam logic [15:0] DQ_OE_ADDR = 16'h8000;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_READ    = 3'h1,
    OP_WRITE   = 3'h2,
    OP_HWRESET = 3'h3,
    OP_SUSPEND = 3'h4
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_WSETUP  = 3'b001,
    S_WPULSE  = 3'b010,
    S_WHOLD   = 3'b011,
    S_RWAIT   = 3'b100,
    S_RSTLOW  = 3'b101,
    S_RSTWAIT = 3'b110,
    S_SUSPW   = 3'b111
  } state_t;

  typedef struct packed {
    logic reset_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic byte_n;
    logic protect_accel_pin;
    logic hv_a9;
  } pin_ctrl_t;

  localparam pin_ctrl_t PINS_IDLE =
    '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage : flash_host_pkg

// *** core/flash_pin_sync.sv ***
module flash_pin_sync #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // pins
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : flash_pin_sync

// *** core/flash_host.sv ***
module flash_host (
  // clock and reset
  input  wire logic                    MCLK_IN,
  input  wire logic                    RESET_IN,
  // apb slave
  input  wire logic                    PSEL_IN,
  input  wire logic                    PENABLE_IN,
  input  wire logic                    PWRITE_IN,
  input  wire logic [7:0]              PADDR_IN,
  input  wire logic [31:0]             PWDATA_IN,
  output logic                         PREADY_OUT,
  output logic      [31:0]             PRDATA_OUT,
  output logic                         PSLVERR_OUT,
  // flash pins
  output flash_host_pkg::pin_ctrl_t    FLASH_PINS_OUT,
  output logic      [22:0]             FLASH_ADDR_OUT,
  output logic      [15:0]             FLASH_DQ_OUT,
  output logic      [15:0]             FLASH_DQ_OE_OUT,
  input  wire logic [15:0]             FLASH_DQ_IN,
  input  wire logic                    FLASH_RB_IN
);
  import flash_host_pkg::*;

  state_t           state;
  logic [CNT_W-1:0] cnt;
  op_t              op;
  logic             go;
  logic             page_en;
  logic             byte_mode;
  logic             hv_id;
  logic             status_chk;
  logic             rst_cmd;
  logic             id_enter;
  logic             resume;
  logic [23:0]      addr;
  logic [15:0]      wdata;
  logic [15:0]      rdata;
  logic             needs_reset;
  logic             id_mode;
  logic             suspended;
  logic             refused;
  logic             page_open;
  logic [19:0]      last_page;
  logic [16:0]      pins_s;
  logic [15:0]      dq_s;
  logic             rb_s;
  logic             access;
  logic             wr_ctrl;
  logic             read_sample;
  logic             write_done;
  logic             reset_done;
  logic             idle;
  logic             short_read;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  flash_pin_sync #(.WIDTH(17)) flash_pin_sync_inst (
    .clk_in   (MCLK_IN),
    .reset_in (RESET_IN),
    .async_in ({FLASH_RB_IN, FLASH_DQ_IN}),
    .sync_out (pins_s)
  );
  assign dq_s = pins_s[15:0];
  assign rb_s = pins_s[16];

  assign access      = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_ctrl     = access & PWRITE_IN & hit(PADDR_IN, REG_CTRL);
  assign idle        = (state == S_IDLE) & ~go;
  assign read_sample = (state == S_RWAIT) && (cnt == '0);
  assign write_done  = (state == S_WHOLD) && (cnt == '0);
  assign reset_done  = (state == S_RSTWAIT) && (cnt == '0);
  assign short_read  = page_open & page_en & ~hv_id &
                       (last_page == addr[22:3]);

  // apb slave, one wait state so every answer comes from a flop
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      if (PSEL_IN & PENABLE_IN & ~PREADY_OUT) begin
        PSLVERR_OUT <= ~(hit(PADDR_IN, REG_CTRL) |
                         hit(PADDR_IN, REG_ADDR) |
                         hit(PADDR_IN, REG_WDATA) |
                         hit(PADDR_IN, REG_RDATA) |
                         hit(PADDR_IN, REG_STATUS));
        PRDATA_OUT  <= 32'h0000_0000;
        if (hit(PADDR_IN, REG_CTRL)) begin
          PRDATA_OUT <= {21'h000000, resume, id_enter, rst_cmd, status_chk,
                         hv_id, FLASH_PINS_OUT.protect_accel_pin,
                         byte_mode, page_en, op};
        end else if (hit(PADDR_IN, REG_ADDR)) begin
          PRDATA_OUT <= {8'h00, addr};
        end else if (hit(PADDR_IN, REG_WDATA)) begin
          PRDATA_OUT <= {16'h0000, wdata};
        end else if (hit(PADDR_IN, REG_RDATA)) begin
          PRDATA_OUT <= {16'h0000, rdata};
        end else if (hit(PADDR_IN, REG_STATUS)) begin
          PRDATA_OUT <= {25'h0000000, page_open, refused, rb_s, suspended,
                         id_mode, needs_reset, ~idle};
        end
      end
    end
  end

  // software registers; control is frozen while an operation runs
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      op         <= OP_NONE;
      go         <= 1'b0;
      page_en    <= 1'b0;
      byte_mode  <= 1'b0;
      hv_id      <= 1'b0;
      status_chk <= 1'b0;
      rst_cmd    <= 1'b0;
      id_enter   <= 1'b0;
      resume     <= 1'b0;
      addr       <= 24'h000000;
      wdata      <= 16'h0000;
      refused    <= 1'b0;
    end else begin
      go <= 1'b0;
      if (access & PWRITE_IN & hit(PADDR_IN, REG_ADDR)) begin
        addr <= PWDATA_IN[23:0];
      end
      if (access & PWRITE_IN & hit(PADDR_IN, REG_WDATA)) begin
        wdata <= PWDATA_IN[15:0];
      end
      if (access & PWRITE_IN & hit(PADDR_IN, REG_STATUS)) begin
        refused <= 1'b0;
      end
      if (wr_ctrl & ~idle) begin
        refused <= 1'b1;
      end else if (wr_ctrl) begin
        op         <= op_t'(PWDATA_IN[CTRL_OP_LSB +: 3]);
        page_en    <= PWDATA_IN[CTRL_PAGE_BIT];
        byte_mode  <= PWDATA_IN[CTRL_BYTE_BIT];
        hv_id      <= PWDATA_IN[CTRL_HVID_BIT];
        status_chk <= PWDATA_IN[CTRL_STCHK_BIT];
        rst_cmd    <= PWDATA_IN[CTRL_RST_BIT];
        id_enter   <= PWDATA_IN[CTRL_IDEN_BIT];
        resume     <= PWDATA_IN[CTRL_RESUM_BIT];
        // array reads are held back until the flash is reset
        if (needs_reset && PWDATA_IN[CTRL_OP_LSB +: 3] == OP_READ &&
            !PWDATA_IN[CTRL_HVID_BIT] && !PWDATA_IN[CTRL_STCHK_BIT]) begin
          refused <= 1'b1;
        end else begin
          go <= (PWDATA_IN[CTRL_OP_LSB +: 3] != OP_NONE);
        end
      end
    end
  end

  // pin sequencer
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      state           <= S_IDLE;
      cnt             <= '0;
      FLASH_PINS_OUT  <= PINS_IDLE;
      FLASH_ADDR_OUT  <= 23'h000000;
      FLASH_DQ_OUT    <= 16'h0000;
      FLASH_DQ_OE_OUT <= 16'h0000;
      page_open       <= 1'b0;
      last_page       <= 20'h00000;
    end else begin
      FLASH_PINS_OUT.byte_n            <= ~byte_mode;
      FLASH_PINS_OUT.protect_accel_pin <= ~(wr_ctrl & idle) ?
        FLASH_PINS_OUT.protect_accel_pin : PWDATA_IN[CTRL_PROT_BIT];
      unique case (state)
        S_IDLE: begin
          if (go) begin
            FLASH_ADDR_OUT  <= addr[22:0];
            FLASH_DQ_OUT    <= {addr[ADDR_LOW_BIT], 15'h0000};
            FLASH_DQ_OE_OUT <= byte_mode ? DQ_OE_ADDR : 16'h0000;
            if (op == OP_READ) begin
              // read strobes with write high; hv at address 9 for id
              FLASH_PINS_OUT.ce_n  <= 1'b0;
              FLASH_PINS_OUT.oe_n  <= 1'b0;
              FLASH_PINS_OUT.we_n  <= 1'b1;
              FLASH_PINS_OUT.hv_a9 <= hv_id;
              cnt <= short_read ? CNT_W'(CYC_PAGE + SYNC_STAGES - 1)
                                : CNT_W'(CYC_ACC + SYNC_STAGES - 1);
              state <= S_RWAIT;
            end else if (op == OP_WRITE) begin
              // a write ends any open page; chip enable rises when the write hold ends
              FLASH_PINS_OUT.ce_n  <= 1'b0;
              FLASH_PINS_OUT.oe_n  <= 1'b1;
              FLASH_PINS_OUT.we_n  <= 1'b1;
              FLASH_PINS_OUT.hv_a9 <= 1'b0;
              FLASH_DQ_OUT    <= byte_mode ?
                {addr[ADDR_LOW_BIT], 7'h00, wdata[7:0]} : wdata;
              FLASH_DQ_OE_OUT <= byte_mode ? DQ_OE_BYTE : DQ_OE_WORD;
              page_open <= 1'b0;
              cnt   <= CNT_W'(CYC_WSU - 1);
              state <= S_WSETUP;
            end else if (op == OP_HWRESET) begin
              FLASH_PINS_OUT.reset_n <= 1'b0;
              FLASH_PINS_OUT.ce_n    <= 1'b1;
              FLASH_PINS_OUT.oe_n    <= 1'b1;
              FLASH_PINS_OUT.hv_a9   <= 1'b0;
              page_open <= 1'b0;
              cnt   <= CNT_W'(CYC_RP - 1);
              state <= S_RSTLOW;
            end else begin
              FLASH_PINS_OUT.ce_n <= 1'b1;
              FLASH_PINS_OUT.oe_n <= 1'b1;
              page_open <= 1'b0;
              cnt   <= CNT_W'(CYC_SUSP - 1);
              state <= S_SUSPW;
            end
          end
        end
        S_RWAIT: begin
          if (cnt == '0) begin
            page_open <= page_en & ~hv_id;
            last_page <= FLASH_ADDR_OUT[22:3];
            if (!(page_en & ~hv_id)) begin
              FLASH_PINS_OUT.ce_n  <= 1'b1;
              FLASH_PINS_OUT.oe_n  <= 1'b1;
              FLASH_PINS_OUT.hv_a9 <= 1'b0;
            end
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_WSETUP: begin
          if (cnt == '0) begin
            FLASH_PINS_OUT.we_n <= 1'b0;
            cnt   <= CNT_W'(CYC_WP - 1);
            state <= S_WPULSE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_WPULSE: begin
          if (cnt == '0) begin
            FLASH_PINS_OUT.we_n <= 1'b1;
            cnt   <= CNT_W'(CYC_WSU - 1);
            state <= S_WHOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_WHOLD: begin
          if (cnt == '0) begin
            FLASH_PINS_OUT.ce_n <= 1'b1;
            FLASH_DQ_OE_OUT <= byte_mode ? DQ_OE_ADDR : 16'h0000;
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_RSTLOW: begin
          if (cnt == '0) begin
            FLASH_PINS_OUT.reset_n <= 1'b1;
            cnt   <= CNT_W'(CYC_RH - 1);
            state <= S_RSTWAIT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_RSTWAIT, S_SUSPW: begin
          if (cnt == '0) begin
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // flash mode tracking; set beats clear in the same cycle
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      needs_reset <= 1'b0;
      id_mode     <= 1'b0;
      suspended   <= 1'b0;
      rdata       <= 16'h0000;
    end else begin
      if (read_sample) begin
        rdata <= byte_mode ? {8'h00, dq_s[7:0]} : dq_s;
      end
      if (reset_done | (write_done & rst_cmd)) begin
        needs_reset <= 1'b0;
        id_mode     <= 1'b0;
        suspended   <= 1'b0;
      end
      if (write_done & resume) begin
        suspended <= 1'b0;
      end
      if (read_sample & status_chk & dq_s[TIMEOUT_FLAG_BIT]) begin
        needs_reset <= 1'b1;
      end
      if (write_done & id_enter) begin
        id_mode <= 1'b1;
      end
      if ((state == S_SUSPW) && (cnt == '0)) begin
        suspended <= 1'b1;
      end
    end
  end

  // reset low-time counter, read only by its checker
  logic [CNT_W-1:0] rst_low_cnt;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN || FLASH_PINS_OUT.reset_n) begin
      rst_low_cnt <= '0;
    end else begin
      rst_low_cnt <= rst_low_cnt + 1'b1;
    end
  end

  chk_read_strobes: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    read_sample |-> !FLASH_PINS_OUT.ce_n && !FLASH_PINS_OUT.oe_n &&
                    FLASH_PINS_OUT.we_n && $past(!FLASH_PINS_OUT.oe_n, 3))
    else $error("read sampled without settled strobes");

  chk_write_cycle: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    $fell(FLASH_PINS_OUT.we_n) |-> !FLASH_PINS_OUT.ce_n &&
      FLASH_PINS_OUT.oe_n && FLASH_DQ_OE_OUT[0] ##2 FLASH_PINS_OUT.we_n)
    else $error("write strobe malformed");

  chk_no_array_read: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (state == S_IDLE && go && op == OP_READ && !hv_id && !status_chk)
      |-> !needs_reset)
    else $error("array read while reset pending");

  chk_timeout_sets: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    (read_sample && status_chk && dq_s[TIMEOUT_FLAG_BIT]) |=> needs_reset)
    else $error("timeout flag not recorded");

  chk_reset_width: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    $rose(FLASH_PINS_OUT.reset_n) |-> rst_low_cnt >= CYC_RP)
    else $error("reset held low too briefly");

  chk_reset_clears: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    reset_done |=> !id_mode && !needs_reset && !suspended)
    else $error("reset did not clear flash mode");

  chk_resume_only: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    $fell(suspended) |-> $past(write_done && (resume || rst_cmd)) ||
                         $past(reset_done))
    else $error("suspend left without resume");

  chk_hv_id_read: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    FLASH_PINS_OUT.hv_a9 |-> FLASH_PINS_OUT.we_n && !FLASH_PINS_OUT.ce_n)
    else $error("high voltage id without read");

endmodule : flash_host

// *** tb/flash_dev_model.sv ***
module flash_dev_model #(
  parameter logic [7:0] MFR_CODE    = 8'h6B,  // arbitrary value
  parameter logic [7:0] DEV_CODE    = 8'h4D,  // arbitrary value
  parameter logic [7:0] SECURE_CODE = 8'h19,
  parameter int         SUSP_NS     = 4000
) (
  // host side
  input  wire flash_host_pkg::pin_ctrl_t pins_in,
  input  wire logic [22:0]               addr_in,
  input  wire logic [15:0]               host_dq_in,
  input  wire logic [15:0]               host_oe_in,
  // device side
  output logic      [15:0]               dq_out,
  output logic                           rb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;

  typedef enum logic [1:0] {M_ARRAY, M_ID, M_FAIL} mode_t;
  mode_t       mode     = M_ARRAY;
  logic        susp     = 1'b0;
  logic [6:0]  susp_sec = 7'h0;
  logic [22:0] cmd_addr = 23'h0;
  logic        page_ok  = 1'b0;
  logic        fast     = 1'b0;
  logic        ready;
  logic        sel;
  logic [19:0] page     = 20'h0;
  logic [15:0] val;
  logic [15:0] drv;
  realtime     t_chg    = 0;

  assign sel = pins_in.reset_n & ~pins_in.ce_n & ~pins_in.oe_n & pins_in.we_n;

  initial begin
    dq_out = 16'h0;
    rb_out = 1'b1;
  end

  always @(negedge pins_in.reset_n) begin
    mode = M_ARRAY;
    susp = 1'b0;
  end

  always @(negedge pins_in.we_n or negedge pins_in.ce_n)
    if (!pins_in.we_n && !pins_in.ce_n) cmd_addr = addr_in;

  // earlier rising strobe: the other one is still low
  always @(posedge pins_in.we_n or posedge pins_in.ce_n) begin
    if (pins_in.we_n ^ pins_in.ce_n) begin
      case (host_dq_in[7:0])
        8'hF0: mode = M_ARRAY;
        8'h90: mode = M_ID;
        8'h55: mode = M_FAIL;  // operation overran its limit
        8'hB0: begin
          susp     = 1'b1;
          susp_sec = cmd_addr[22:16];
          rb_out   = 1'b0;
          rb_out <= #(SUSP_NS) 1'b1;  // pause well inside 20 us
        end
        8'h30: susp = 1'b0;
        default: ;  // program done at once, mode kept
      endcase
    end
  end

  always @(addr_in or pins_in or host_dq_in[15]) begin
    if (pins_in.ce_n) page_ok = 1'b0;
    fast  = page_ok && (addr_in[22:3] == page);
    t_chg = $realtime;
  end

  always @* begin : pick
    logic [15:0] v;
    v = 16'h0000;
    if (mode == M_FAIL) v = 16'h1 << TIMEOUT_FLAG_BIT;
    else if (mode == M_ID || pins_in.hv_a9) begin
      case ({addr_in[3], addr_in[1:0]})
        3'b000:  v = {8'h00, MFR_CODE};
        3'b010:  v = {15'h0, !pins_in.protect_accel_pin
                             && &addr_in[22:16]};
        3'b011:  v = {8'h00, SECURE_CODE};
        default: v = {8'h00, DEV_CODE};
      endcase
    end else if (susp && addr_in[22:16] == susp_sec) v = 16'h0088;
    else v = addr_in[15:0] ^ 16'h3C5A;
    if (!pins_in.byte_n) v = {8'h00, host_dq_in[15] ? v[15:8] : v[7:0]};
    val = v;
  end

  // data is wrong until the access time runs out; released bits wander
  always #1 begin
    ready = ($realtime - t_chg) >= (fast ? T_PAGE_NS : T_ACC_NS);
    if (sel && ready) begin
      page    = addr_in[22:3];
      page_ok = 1'b1;
    end
    drv = !sel ? 16'h0 : pins_in.byte_n ? 16'hFFFF : 16'h00FF;
    dq_out = (host_oe_in & host_dq_in) | (~host_oe_in & drv & (ready ? val : ~val))
           | (~host_oe_in & ~drv & ~dq_out);
  end
endmodule : flash_dev_model

// *** tb/flash_host_tb.sv ***
module flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;

  localparam logic [7:0]  MFR = 8'h6B;  // arbitrary value
  localparam logic [22:0] A   = 23'h012340;
  localparam logic [31:0] P   = 32'h1 << CTRL_PROT_BIT,
                          PG  = 32'h1 << CTRL_PAGE_BIT,
                          BY  = 32'h1 << CTRL_BYTE_BIT,
                          HV  = 32'h1 << CTRL_HVID_BIT,
                          SC  = 32'h1 << CTRL_STCHK_BIT,
                          RC  = 32'h1 << CTRL_RST_BIT,
                          ID  = 32'h1 << CTRL_IDEN_BIT,
                          RS  = 32'h1 << CTRL_RESUM_BIT;

  logic        clk, rst, psel, pen, pwr, pready, pslverr, rb, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic [22:0] faddr;
  logic [15:0] fdq, fdq_oe, dq_in, w;
  pin_ctrl_t   pins;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          we_cnt = 0;

  flash_host flash_host_inst (
    .MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
    .FLASH_PINS_OUT(pins), .FLASH_ADDR_OUT(faddr), .FLASH_DQ_OUT(fdq),
    .FLASH_DQ_OE_OUT(fdq_oe), .FLASH_DQ_IN(dq_in), .FLASH_RB_IN(rb));

  flash_dev_model #(.MFR_CODE(MFR)) flash_dev_model_inst (
    .pins_in(pins), .addr_in(faddr), .host_dq_in(fdq),
    .host_oe_in(fdq_oe), .dq_out(dq_in), .rb_out(rb));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] rq);
    xfer(1'b0, a, 32'h0, rq, e);
  endtask : rd

  task wait_idle;
    s = 32'h1;
    // only the bench timeout ends a stuck busy flag
    while (s[ST_BUSY] !== 1'b0) rd(REG_STATUS, s);
  endtask : wait_idle

  task run(input logic [31:0] c);
    wr(REG_CTRL, c);
    wait_idle;
  endtask : run

  task fread(input logic [23:0] a, input logic [31:0] c,
             output logic [31:0] rq);
    wr(REG_ADDR, {8'h0, a});
    run(c | OP_READ);
    rd(REG_RDATA, rq);
  endtask : fread

  task fcmd(input logic [22:0] a, input logic [7:0] d, input logic [31:0] c);
    wr(REG_ADDR, {9'h0, a});
    wr(REG_WDATA, {24'h0, d});
    run(c | OP_WRITE);
  endtask : fcmd

  // a hang ends the run here
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end

  always @(posedge clk) begin
    if (!rst && !pins.oe_n) begin
      chk("dq_oe", pins.byte_n ? 16'h0 : DQ_OE_ADDR, fdq_oe);
      chk("we_read", 1, pins.we_n);
    end
    if (!rst && !pins.we_n) chk("ce_write", 0, pins.ce_n);
    if (!rst && pins.we_n && we_cnt != 0) chk("we_wid", CYC_WP, we_cnt);
    we_cnt = pins.we_n ? 0 : we_cnt + 1;
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    w = A[15:0] ^ 16'h3C5A;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pins_idle", PINS_IDLE, pins);
    rd(REG_STATUS, s);
    chk("status_rst", 32'h10, s);
    xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped", 1, e);
    fread({1'b0, A}, P, q);
    chk("rd_word", w, q);
    fread({1'b0, A}, P | PG, q);
    chk("page_first", w, q);
    fread({1'b0, A + 23'd5}, P | PG, q);
    chk("page_hit", w ^ 16'h5, q);
    rd(REG_STATUS, s);
    chk("page_open", 1, s[ST_PAGE]);
    fread({1'b0, A + 23'd8}, P | PG, q);
    chk("page_new", w ^ 16'h8, q);
    fread({1'b1, A}, P | BY, q);
    chk("byte_hi", {8'h0, w[15:8]}, q);
    fread({1'b0, A}, P | BY, q);
    chk("byte_lo", {8'h0, w[7:0]}, q);
    fcmd(A, 8'h90, P | ID);
    rd(REG_STATUS, s);
    chk("id_mode", 1, s[ST_IDMODE]);
    fread(24'h0, P, q);
    chk("id_mfr", MFR, q);
    fcmd(23'h0, 8'hF0, P | RC);
    rd(REG_STATUS, s);
    chk("id_left", 0, s[ST_IDMODE]);
    fread({1'b0, A}, P, q);
    chk("rd_after_id", w, q);
    fread(24'h7F0002, HV, q);
    chk("lock_prot", 1, q);
    fread(24'h7F0002, HV | P, q);
    chk("lock_free", 0, q);
    fread(24'h000003, HV | P, q);
    chk("secure", 32'h19, q);
    fcmd(A, 8'h55, P);
    fread({1'b0, A}, P | SC, q);
    chk("flag_bit", 1, q[TIMEOUT_FLAG_BIT]);
    fread({1'b0, A}, P, q);
    rd(REG_STATUS, s);
    chk("refused", 32'h22, s & 32'h23);
    wr(REG_STATUS, 32'h0);
    run(P | OP_HWRESET);
    rd(REG_STATUS, s);
    chk("reset_clr", 32'h10, s & 32'h3F);
    fread({1'b0, A}, P, q);
    chk("rd_after_rst", w, q);
    fcmd(23'h050000, 8'hB0, P);
    wr(REG_CTRL, P | OP_SUSPEND);
    wr(REG_CTRL, P | OP_READ);
    wait_idle;
    rd(REG_STATUS, s);
    chk("suspended", 32'h38, s & 32'h3F);
    wr(REG_STATUS, 32'h0);
    fread(24'h050004, P, q);
    chk("erase_stat", 32'h88, q);
    fcmd(A, 8'h77, P);
    rd(REG_STATUS, s);
    chk("still_susp", 1, s[ST_SUSP]);
    fcmd(23'h0, 8'h30, P | RS);
    rd(REG_STATUS, s);
    chk("resumed", 0, s[ST_SUSP]);
    fread(24'h050004, P, q);
    chk("rd_resumed", 32'h3C5E, q);
    complete_run;
  end
endmodule : flash_host_tb
